/* File: verilog/eeprom_pkg.sv */
package eeprom_pkg;

  // ==========================================================================
  // Command codes, first byte of every frame.
  localparam logic [7:0] OP_ENABLE_WRITES = 8'h06;
  localparam logic [7:0] OP_DISABLE_WRITES = 8'h04;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_STATUS_STORE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_COUNTER_STORE = 8'h07;

  // ==========================================================================
  // Array geometry.
  localparam int MEM_BYTES = 1024;
  localparam int ADDR_W = 10;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam logic [ADDR_W-1:0] COUNTER_PAGE_END = 10'h020;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3FF;
  localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 10'h300;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 10'h200;

  // ==========================================================================
  // Status byte layout and delivered values.
  localparam int ST_LOCK = 7;
  localparam int ST_PS_HI = 3;
  localparam int ST_PS_LO = 2;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [1:0] PS_RESET = 2'h0;

  // ==========================================================================
  // Timing: serial clock ceiling against the system clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_MAX_KHZ = 5000;
  localparam int SCLK_HALF_CYCLES = (1000000 / SCLK_MAX_KHZ / 2) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_OPCODE = 3'h1,
    L_ADDR = 3'h2,
    L_RX = 3'h3,
    L_TX = 3'h4,
    L_STATUS_RX = 3'h5,
    L_HOLD = 3'h6
  } link_state_e;

  typedef enum logic [2:0] {
    E_CLEAR = 3'h0,
    E_IDLE = 3'h1,
    E_DRAIN = 3'h2,
    E_CNT_LO = 3'h3,
    E_TIME = 3'h4
  } engine_state_e;

endpackage

/* File: verilog/byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  // ==========================================================================
  // Storage. DEPTH must be a power of two so the pointers wrap cleanly.
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  wire [AW:0] fill = wr_ptr - rd_ptr;
  wire push = in_valid_i & in_ready_o & ce_i;
  wire pop = out_valid_o & out_ready_i & ce_i;

  assign in_ready_o = fill != DEPTH_C;
  assign out_valid_o = fill != '0;
  assign out_data_o = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce_i && flush_i) begin
      rd_ptr <= wr_ptr;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verilog/serial_eeprom_write_protect.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Respond only while selected; sample on rising clock.
// - Drive output bit after each falling clock.
// - Deselected output floats; standby unless writing.
// - Ignore bus until first select falling edge.
// - Array of 1024 bytes in 32-byte pages.
// - First page: sixteen counters, only increase.
// - Byte and page writes, none on counter page.
// - Status byte layout lock to busy.
// - Latch and busy change only internally.
// - Lock clear: status write needs only latch.
// - Lock set, pin high: status write allowed.
// - Lock set, pin low: status writes ignored.
// - Hard lock makes protected bytes read-only.
// - Hard lock entered by last of both.
// - Hard lock left only by pin high or by reset.
// - Pin held high never gives hard lock.
// - Floating protect pin counts as low.
// - Protected region refused; others need latch.
// - Seven opcodes start every command.
// - Latch set before writes, cleared after.
// - Everything shifted most significant bit first.
// - Size bits select none, quarter or half.
module serial_eeprom_write_protect
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = 500,
  parameter int FIFO_DEPTH = PAGE_BYTES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  input wire logic wp_n_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  output logic standby_o
);

  // ==========================================================================
  // Pin synchronisers and edge finders.
  // The serial clock is oversampled, so it must stay well below the system
  // clock; ten system cycles per half period is what 5 MHz leaves.
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(WRITE_CYCLES - 1);

  logic [2:0] sclk_q;
  logic [2:0] sel_q;
  logic [1:0] mosi_q;
  logic [1:0] wp_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sclk_q <= 3'h0;
      sel_q <= 3'h7;
      mosi_q <= 2'h0;
      wp_q <= 2'h0;
    end else if (ce_i) begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      sel_q <= {sel_q[1:0], sel_n_i};
      mosi_q <= {mosi_q[0], mosi_i};
      wp_q <= {wp_q[0], wp_n_i};
    end
  end

  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire selected = ~sel_q[1];
  wire sel_fall = ~sel_q[1] & sel_q[2];
  wire sel_rise = sel_q[1] & ~sel_q[2];
  wire mosi_s = mosi_q[1];
  wire wp_high = wp_q[1];

  // ==========================================================================
  // State declarations.
  link_state_e state;
  link_state_e next_state;
  link_state_e op_state;
  engine_state_e eng_state;
  engine_state_e next_eng;

  logic [2:0] bit_idx;
  logic [7:0] shift_in;
  logic [7:0] opcode;
  logic addr_second;
  logic [1:0] addr_top;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] tx_byte;
  logic sr_pending;
  logic [7:0] sr_data;
  logic write_latch;
  logic status_lock;
  logic [1:0] protect_size;
  logic compare_flag;
  logic erased_flag;
  logic [ADDR_W-1:0] wr_ptr;
  logic cnt_mode;
  logic hi_have;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;
  logic [TW-1:0] timer;
  logic [7:0] mem [MEM_BYTES];

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_data;

  // ==========================================================================
  // Protection decode.
  wire busy_flag = eng_state != E_IDLE;
  wire hard_lock_mode = status_lock & ~wp_high;
  wire [ADDR_W-1:0] prot_base = protect_size[1] ? PROT_HALF_BASE : PROT_QUARTER_BASE;
  wire region_hit = (protect_size != 2'h0) && (wr_ptr >= prot_base);
  wire [7:0] status_byte = {status_lock, erased_flag, 1'b0, compare_flag,
                            protect_size, write_latch, busy_flag};

  // ==========================================================================
  // Serial front end.
  wire link_rise = ce_i & sclk_rise & selected & ~sel_fall & (state != L_IDLE);
  wire byte_done = link_rise & (bit_idx == 3'h7);
  wire [7:0] rx_byte = {shift_in[6:0], mosi_s};
  wire opcode_done = byte_done & (state == L_OPCODE);
  wire addr_done = byte_done & (state == L_ADDR) & addr_second;
  wire [ADDR_W-1:0] full_addr = {addr_top, rx_byte};
  wire is_read = opcode == OP_ARRAY_READ;
  wire write_ok = write_latch & ~busy_flag;
  wire set_latch = opcode_done & (rx_byte == OP_ENABLE_WRITES) & ~busy_flag;
  wire sr_commit = ce_i & sel_rise & sr_pending & ~hard_lock_mode & ~busy_flag;
  wire wr_commit = ce_i & sel_rise & (state == L_RX) & (bit_idx == 3'h0) & fifo_out_valid;
  wire clr_latch = (opcode_done & (rx_byte == OP_DISABLE_WRITES)) | sr_commit | wr_commit;
  wire rx_push = byte_done & (state == L_RX) & fifo_in_ready;
  wire link_flush = ce_i & sel_rise & (state == L_RX) & ~wr_commit;
  wire tx_load = (opcode_done & (rx_byte == OP_STATUS_FETCH)) | (addr_done & is_read)
                 | (byte_done & (state == L_TX));
  wire [ADDR_W-1:0] rd_sel = addr_done ? full_addr : rd_addr;
  wire status_src = (state == L_OPCODE) | (opcode == OP_STATUS_FETCH);
  wire [7:0] tx_src = status_src ? status_byte : mem[rd_sel];

  always_comb begin
    case (rx_byte)
      OP_STATUS_FETCH: op_state = L_TX;
      OP_STATUS_STORE: op_state = (write_ok & ~hard_lock_mode) ? L_STATUS_RX : L_HOLD;
      OP_ARRAY_READ: op_state = busy_flag ? L_HOLD : L_ADDR;
      OP_ARRAY_WRITE: op_state = write_ok ? L_ADDR : L_HOLD;
      OP_COUNTER_STORE: op_state = write_ok ? L_ADDR : L_HOLD;
      default: op_state = L_HOLD;
    endcase
  end

  always_comb begin
    next_state = state;
    if (!selected) begin
      next_state = L_IDLE;
    end else if (sel_fall) begin
      next_state = L_OPCODE;
    end else if (byte_done) begin
      case (state)
        L_OPCODE: next_state = op_state;
        L_ADDR: next_state = addr_second ? (is_read ? L_TX : L_RX) : L_ADDR;
        L_STATUS_RX: next_state = L_HOLD;
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= L_IDLE;
      bit_idx <= 3'h0;
      shift_in <= 8'h00;
      addr_second <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      if (sel_fall) begin
        bit_idx <= 3'h0;
        addr_second <= 1'b0;
      end else if (link_rise) begin
        bit_idx <= bit_idx + 1'b1;
        shift_in <= rx_byte;
        if (byte_done && state == L_ADDR) begin
          addr_second <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      opcode <= 8'h00;
      addr_top <= 2'h0;
      wr_addr <= '0;
    end else begin
      if (opcode_done) begin
        opcode <= rx_byte;
      end
      if (byte_done && state == L_ADDR && !addr_second) begin
        addr_top <= rx_byte[1:0];
      end
      if (addr_done) begin
        wr_addr <= full_addr;
      end
    end
  end

  // A status byte only counts if the frame ends before another rising clock edge.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sr_pending <= 1'b0;
      sr_data <= 8'h00;
    end else if (byte_done && state == L_STATUS_RX) begin
      sr_pending <= 1'b1;
      sr_data <= rx_byte;
    end else if (link_rise || (ce_i && sel_rise)) begin
      sr_pending <= 1'b0;
    end
  end

  // ==========================================================================
  // Serial output.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_byte <= 8'h00;
      rd_addr <= '0;
      miso_o <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      if (!selected) begin
        miso_oe_n_o <= 1'b1;
      end else if (sclk_fall && state == L_TX) begin
        miso_oe_n_o <= 1'b0;
      end
      if (tx_load) begin
        tx_byte <= tx_src;
        rd_addr <= rd_sel + 1'b1;
      end else if (sclk_fall && selected && state == L_TX) begin
        miso_o <= tx_byte[7];
        tx_byte <= {tx_byte[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      write_latch <= 1'b0;
      standby_o <= 1'b0;
    end else if (ce_i) begin
      standby_o <= ~selected & ~busy_flag;
      if (set_latch) begin
        write_latch <= 1'b1;
      end else if (clr_latch) begin
        write_latch <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Write engine. Bytes wait in the FIFO until the frame closes cleanly, so
  // a frame cut short writes nothing at all.
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) page_buffer (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .flush_i(link_flush | (eng_state == E_TIME)),
    .in_valid_i(rx_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_byte),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(eng_state == E_DRAIN),
    .out_data_o(fifo_data)
  );

  wire pop = ce_i & fifo_out_valid & (eng_state == E_DRAIN);
  wire [ADDR_W-1:0] pair_hi = {wr_ptr[ADDR_W-1:1], 1'b0};
  wire [ADDR_W-1:0] pair_lo = {wr_ptr[ADDR_W-1:1], 1'b1};
  wire cnt_second = pop & cnt_mode & hi_have;
  wire cnt_greater = {hi_byte, fifo_data} > {mem[pair_hi], mem[pair_lo]};
  wire in_clear = eng_state == E_CLEAR;
  wire in_cnt_lo = eng_state == E_CNT_LO;
  wire mem_we = ce_i & (in_clear | (pop & ~cnt_mode & ~region_hit)
                | (cnt_second & cnt_greater) | in_cnt_lo);
  wire [ADDR_W-1:0] mem_wa = cnt_second ? pair_hi : (in_cnt_lo ? pair_lo : wr_ptr);
  wire [7:0] mem_wd = in_clear ? 8'h00 : (cnt_second ? hi_byte : (in_cnt_lo ? lo_byte : fifo_data));

  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_comb begin
    case (eng_state)
      E_CLEAR: next_eng = (wr_ptr == LAST_ADDR) ? E_IDLE : E_CLEAR;
      E_IDLE: next_eng = wr_commit ? E_DRAIN : (sr_commit ? E_TIME : E_IDLE);
      E_DRAIN: begin
        if (cnt_second) begin
          next_eng = cnt_greater ? E_CNT_LO : E_TIME;
        end else begin
          next_eng = fifo_out_valid ? E_DRAIN : E_TIME;
        end
      end
      E_CNT_LO: next_eng = E_TIME;
      E_TIME: next_eng = (timer == TIMER_LAST) ? E_IDLE : E_TIME;
      default: next_eng = E_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      eng_state <= E_CLEAR;
      wr_ptr <= '0;
      cnt_mode <= 1'b0;
      hi_have <= 1'b0;
      hi_byte <= 8'h00;
      lo_byte <= 8'h00;
      timer <= '0;
    end else if (ce_i) begin
      eng_state <= next_eng;
      timer <= (eng_state == E_TIME) ? timer + 1'b1 : '0;
      if (in_clear) begin
        wr_ptr <= wr_ptr + 1'b1;
      end else if (wr_commit) begin
        wr_ptr <= wr_addr;
        cnt_mode <= wr_addr < COUNTER_PAGE_END;
        hi_have <= 1'b0;
      end else if (pop && cnt_mode && !hi_have) begin
        hi_byte <= fifo_data;
        hi_have <= 1'b1;
      end else if (cnt_second) begin
        lo_byte <= fifo_data;
      end else if (pop) begin
        wr_ptr <= {wr_ptr[ADDR_W-1:PAGE_BITS], wr_ptr[PAGE_BITS-1:0] + 1'b1};
      end
    end
  end

  // The non-volatile bits come back at their delivered values after reset.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status_lock <= LOCK_RESET;
      protect_size <= PS_RESET;
      compare_flag <= 1'b0;
      erased_flag <= 1'b0;
    end else if (ce_i) begin
      if (sr_commit) begin
        status_lock <= sr_data[ST_LOCK];
        protect_size <= {sr_data[ST_PS_HI], sr_data[ST_PS_LO]};
      end
      if (in_clear && next_eng == E_IDLE) begin
        erased_flag <= 1'b1;
      end else if (mem_we && !in_clear) begin
        erased_flag <= 1'b0;
      end
      if (cnt_second) begin
        compare_flag <= ~cnt_greater;
      end
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_cnt_low;
    cnt_second && !cnt_greater;
  endsequence
  sequence s_cnt_refused;
    compare_flag && eng_state == E_TIME;
  endsequence

  property p_deselect_idle;
    (ce_i && !selected) |=> state == L_IDLE;
  endproperty
  a_deselect_idle: assert property (p_deselect_idle) else $error("link active while deselected");

  property p_out_on_fall;
    $changed(miso_o) |-> $past(sclk_fall) && $past(ce_i);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output bit moved off a falling edge");

  property p_deselect_hiz;
    (ce_i && !selected) |=> miso_oe_n_o;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz) else $error("output driven while deselected");

  property p_wait_select;
    (state == L_IDLE && !(ce_i && sel_fall)) |=> state == L_IDLE;
  endproperty
  a_wait_select: assert property (p_wait_select) else $error("left idle without select falling");

  property p_counter_monotonic;
    s_cnt_low |=> s_cnt_refused;
  endproperty
  a_counter_monotonic: assert property (p_counter_monotonic) else $error("lower counter value taken");

  property p_latch_internal;
    $changed(write_latch) |-> $past(set_latch || clr_latch);
  endproperty
  a_latch_internal: assert property (p_latch_internal) else $error("latch moved without cause");

  property p_hw_refuse;
    (opcode_done && rx_byte == OP_STATUS_STORE && hard_lock_mode) |=> state == L_HOLD;
  endproperty
  a_hw_refuse: assert property (p_hw_refuse) else $error("status store taken in hard lock");

  property p_hw_frozen;
    hard_lock_mode |=> $stable(status_lock) && $stable(protect_size);
  endproperty
  a_hw_frozen: assert property (p_hw_frozen) else $error("protect setting changed in hard lock");

  property p_hw_release;
    hard_lock_mode ##1 !hard_lock_mode |-> wp_high;
  endproperty
  a_hw_release: assert property (p_hw_release) else $error("hard lock left with pin low");

  property p_region_refused;
    (mem_we && !in_clear && protect_size != 2'h0) |-> mem_wa < prot_base;
  endproperty
  a_region_refused: assert property (p_region_refused) else $error("protected byte written");

  property p_read_decode;
    (opcode_done && rx_byte == OP_ARRAY_READ && !busy_flag) |=> state == L_ADDR;
  endproperty
  a_read_decode: assert property (p_read_decode) else $error("read opcode not decoded");

  property p_latch_cleared;
    wr_commit |=> !write_latch && eng_state == E_DRAIN;
  endproperty
  a_latch_cleared: assert property (p_latch_cleared) else $error("latch kept after array write");

endmodule

`default_nettype wire

/* File: verification/spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bus master model. The link clock idles low and stands still between frames.
module spi_master_model (
  input wire logic clk_sys_i,
  input wire logic miso_i,
  input wire logic miso_oe_n_i,
  output logic sclk_o,
  output logic sel_n_o,
  output logic mosi_o
);
  wire miso_line = miso_oe_n_i ? 1'bz : miso_i;

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Four system cycles a half period give the 80 ns link clock.
  // Read data is taken late in the high phase, where it has long settled.
  task automatic frame(input int nbits, input logic [319:0] tx, output logic [319:0] rx);
    rx = '0;
    sel_n_o = 1'b0;
    tick(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_o = tx[i];
      tick(4);
      sclk_o = 1'b1;
      tick(4);
      rx = {rx[318:0], miso_line};
      sclk_o = 1'b0;
    end
    tick(4);
    sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    tick(8);
  endtask

  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
endmodule

`default_nettype wire

/* File: verification/serial_eeprom_write_protect_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_write_protect_tb
  import eeprom_pkg::*;
;
  logic clk_sys_i;
  logic sys_rst_i;
  logic wp_n_i;
  wire sclk;
  wire sel_n;
  wire mosi;
  wire miso;
  wire miso_oe_n;
  wire standby;
  int n_fail = 0;
  int n_tests = 0;
  logic [319:0] rx;
  logic [319:0] tx;
  logic [7:0] st;

  // A long write time keeps busy visible across a whole status frame.
  serial_eeprom_write_protect #(.WRITE_CYCLES(400)) dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .sclk_i(sclk),
    .sel_n_i(sel_n), .mosi_i(mosi), .wp_n_i(wp_n_i), .miso_o(miso),
    .miso_oe_n_o(miso_oe_n), .standby_o(standby));

  spi_master_model m_u (.clk_sys_i(clk_sys_i), .miso_i(miso), .miso_oe_n_i(miso_oe_n),
    .sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================================
  // Access tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks run: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmd(input int nbits, input logic [319:0] t);
    m_u.frame(nbits, t, rx);
  endtask

  task automatic status();
    cmd(16, {OP_STATUS_FETCH, 8'h00});
    st = rx[7:0];
  endtask

  task automatic wait_idle();
    status();
    for (int i = 0; i < 40 && st[0] !== 1'b0; i++) begin
      status();
    end
    check(st[0], 1'b0, "write never finished");
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic latch);
    if (latch) begin
      cmd(8, OP_ENABLE_WRITES);
    end
    cmd(32, {OP_ARRAY_WRITE, 6'h00, a, d});
    wait_idle();
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
    cmd(32, {OP_ARRAY_READ, 6'h00, a, 8'h00});
    check(rx[7:0], exp, what);
  endtask

  task automatic sr_chk(input logic [7:0] v, input logic [7:0] exp, input string what);
    cmd(8, OP_ENABLE_WRITES);
    cmd(16, {OP_STATUS_STORE, v});
    wait_idle();
    check(st & 8'h8F, exp, what);
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    sys_rst_i = 1'b1;
    wp_n_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check(miso_oe_n, 1'b1, "output driven in reset");
    sys_rst_i = 1'b0;
    wait_idle();
    check(st, 8'h40, "delivered status");
    check({miso_oe_n, standby}, 2'b11, "deselected state");
    cmd(8, OP_ENABLE_WRITES);
    status();
    check(st, 8'h42, "latch set");
    cmd(8, OP_DISABLE_WRITES);
    status();
    check(st, 8'h40, "latch cleared");
    cmd(8, OP_ENABLE_WRITES);
    cmd(32, {OP_ARRAY_WRITE, 16'h0300, 8'h77});
    status();
    check(st[1:0], 2'b01, "busy with latch dropped");
    check(standby, 1'b0, "standby while busy");
    wait_idle();
    wr(10'h200, 8'h66, 1'b1);
    wr(10'h200, 8'hA5, 1'b0);
    rd_chk(10'h300, 8'h77, "byte write");
    rd_chk(10'h200, 8'h66, "write without latch");
    // Page write that starts near the page end and wraps inside it.
    cmd(8, OP_ENABLE_WRITES);
    tx = {OP_ARRAY_WRITE, 16'h02F8};
    for (int i = 0; i < 32; i++) begin
      tx = {tx[311:0], 8'(i + 1)};
    end
    cmd(280, tx);
    wait_idle();
    cmd(280, {OP_ARRAY_READ, 16'h02E0, 256'h0});
    for (int j = 0; j < 32; j++) begin
      check(rx[255 - 8 * j -: 8], 8'((j + 8) % 32 + 1), "page data");
    end
    cmd(8, OP_ENABLE_WRITES);
    cmd(40, {OP_COUNTER_STORE, 16'h0004, 16'h1234});
    wait_idle();
    check(st[4], 1'b0, "counter raise");
    cmd(8, OP_ENABLE_WRITES);
    cmd(40, {OP_ARRAY_WRITE, 16'h0004, 16'h1233});
    wait_idle();
    check(st[4], 1'b1, "counter lowered");
    cmd(40, {OP_ARRAY_READ, 16'h0004, 16'h0000});
    check(rx[15:0], 16'h1234, "counter value");
    sr_chk(8'h04, 8'h04, "size quarter");
    wr(10'h300, 8'h88, 1'b1);
    wr(10'h200, 8'h99, 1'b1);
    sr_chk(8'h08, 8'h08, "size half");
    wr(10'h200, 8'h55, 1'b1);
    rd_chk(10'h300, 8'h77, "quarter protected");
    rd_chk(10'h200, 8'h99, "half protected");
    sr_chk(8'h88, 8'h88, "lock set, pin high");
    sr_chk(8'h84, 8'h84, "locked, pin high");
    wp_n_i = 1'b0;
    sr_chk(8'h80, 8'h86, "pin falls after lock");
    wr(10'h300, 8'h11, 1'b1);
    rd_chk(10'h300, 8'h77, "hard read-only area");
    wp_n_i = 1'b1;
    sr_chk(8'h04, 8'h04, "pin high releases");
    wp_n_i = 1'b0;
    sr_chk(8'h80, 8'h80, "lock with pin low");
    sr_chk(8'h00, 8'h82, "lock after pin low");
    wp_n_i = 1'b1;
    sr_chk(8'h03, 8'h00, "flags not writable");
    cmd(8, OP_ENABLE_WRITES);
    cmd(32, {8'h12, 6'h00, 10'h3F0, 8'h5A});
    status();
    check(st[1:0], 2'b10, "unknown opcode ignored");
    rd_chk(10'h3F0, 8'h00, "unknown opcode wrote nothing");
    sr_chk(8'h0C, 8'h0C, "both size bits");
    wr(10'h200, 8'h44, 1'b1);
    rd_chk(10'h200, 8'h99, "both size bits protect half");
    test_done();
  end

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    n_fail++;
    test_done();
  end
endmodule

`default_nettype wire
